// [hdl/sqs_map.vh]
`ifndef SQS_MAP_VH
`define SQS_MAP_VH
// ============================================================
// Register offsets.
`define SQS_ADDR_SUPPLY      4'h3
`define SQS_ADDR_QUICK       4'h4
// ============================================================
// Header, rail flag and quick status field positions.
`define SQS_ADDR_HI          15
`define SQS_ADDR_LO          12
`define SQS_BIT_FAIL         11
`define SQS_BIT_SUPPLY_SUM   10
`define SQS_BIT_DC           9
`define SQS_BIT_DEVICE_SUM   8
`define SQS_BIT_A_OV         7
`define SQS_BIT_A_UV         6
`define SQS_BIT_B_OV         5
`define SQS_BIT_B_UV         4
`define SQS_BIT_C_OV         3
`define SQS_BIT_C_UV         2
`define SQS_BIT_D_OV         1
`define SQS_BIT_D_UV         0
`define SQS_QUICK_HI         7
`define SQS_QUICK_LO         0
// ============================================================
// Reset values.
`define SQS_RST_FLAGS        8'h00
`define SQS_RST_WORD         16'h0000
`endif

// [hdl/sqs_status_regs.v]
// Functional notes
// - Bit 11 reads one in fail mode with pin direct control, zero otherwise.
// - Bit 10 is the OR of all eight rail overvoltage and undervoltage flags.
// - Bit 8 ORs logic supply, frame, fallback, pwm clock, resistor, watchdog faults.
// - Bit 9 is read-only with no meaning; it reads zero here.
// - Rail A overvoltage sets bit 7, undervoltage bit 6; clears outputs 1 and 2.
// - Rail B overvoltage sets bit 5, undervoltage bit 4; clears outputs 3 and 4.
// - Rail C overvoltage sets bit 3, undervoltage bit 2; clears outputs 5 and 6.
// - Rail D overvoltage sets bit 1, undervoltage bit 0; clears outputs 7 and 8.
// - Each rail flag latches on its event and stays after the condition ends.
// - Quick status bits 7:0 OR each channel's thermal, overcurrent and open-load flags.
// - Supply status at offset 0x03, quick status at 0x04; after reset both read zero except their offset in bits 15:12.
`timescale 1ns/1ps
`include "sqs_map.vh"
module sqs_status_regs (
    input  wire        clk,
    input  wire        reset_n,
    input  wire        reg_rd,
    input  wire        reg_wr,
    input  wire [3:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    output reg         reg_rvalid,
    input  wire        fail_mode_flag,
    input  wire        switch_supply_a_ov,
    input  wire        switch_supply_a_uv,
    input  wire        switch_supply_b_ov,
    input  wire        switch_supply_b_uv,
    input  wire        switch_supply_c_ov,
    input  wire        switch_supply_c_uv,
    input  wire        switch_supply_d_ov,
    input  wire        switch_supply_d_uv,
    input  wire        logic_supply_fault,
    input  wire        serial_frame_fault,
    input  wire        fallback_input,
    input  wire        pwm_clock_fault,
    input  wire        ext_resistor_fault,
    input  wire        watchdog_error,
    input  wire [7:0]  channel_thermal_shutdown,
    input  wire [7:0]  channel_thermal_warn_high,
    input  wire [7:0]  channel_thermal_warn_low,
    input  wire [7:0]  channel_overcurrent,
    input  wire [7:0]  channel_open_load,
    input  wire [7:0]  channel_output_enable_req,
    output reg  [7:0]  channel_output_enable
);

// ============================================================
// Input synchronisers. Detector levels come from analog comparators, so
// each passes two flops before anything looks at it.
wire [7:0]  rail_raw;
wire [6:0]  dev_raw;
wire [39:0] chn_raw;
reg  [7:0]  rail_s1_r;
reg  [7:0]  rail_s2_r;
reg  [6:0]  dev_s1_r;
reg  [6:0]  dev_s2_r;
reg  [39:0] chn_s1_r;
reg  [39:0] chn_s2_r;

assign rail_raw = {switch_supply_a_ov,
                   switch_supply_a_uv,
                   switch_supply_b_ov,
                   switch_supply_b_uv,
                   switch_supply_c_ov,
                   switch_supply_c_uv,
                   switch_supply_d_ov,
                   switch_supply_d_uv};

assign dev_raw = {fail_mode_flag,
                  logic_supply_fault,
                  serial_frame_fault,
                  fallback_input,
                  pwm_clock_fault,
                  ext_resistor_fault,
                  watchdog_error};

assign chn_raw = {channel_thermal_shutdown,
                  channel_thermal_warn_high,
                  channel_thermal_warn_low,
                  channel_overcurrent,
                  channel_open_load};

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        rail_s1_r <= 8'h00;
        rail_s2_r <= 8'h00;
    end else begin
        rail_s1_r <= rail_raw;
        rail_s2_r <= rail_s1_r;
    end
end

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        dev_s1_r <= 7'h00;
        dev_s2_r <= 7'h00;
    end else begin
        dev_s1_r <= dev_raw;
        dev_s2_r <= dev_s1_r;
    end
end

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        chn_s1_r <= 40'h0000000000;
        chn_s2_r <= 40'h0000000000;
    end else begin
        chn_s1_r <= chn_raw;
        chn_s2_r <= chn_s1_r;
    end
end

// ============================================================
// Latched rail flags. Bit order matches the word: 7 is rail A overvoltage.
reg  [7:0] rail_flag_r;
reg  [7:0] rail_flag_nxt;
wire       wr_supply;

assign wr_supply = reg_wr && (reg_addr == `SQS_ADDR_SUPPLY);

always @* begin
    rail_flag_nxt = rail_flag_r;
    // Write one to clear; a new event in the same cycle wins over the clear.
    if (wr_supply) begin
        rail_flag_nxt = rail_flag_nxt & ~reg_wdata[7:0];
    end
    rail_flag_nxt = rail_flag_nxt | rail_s2_r;
end

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        rail_flag_r <= `SQS_RST_FLAGS;
    end else begin
        rail_flag_r <= rail_flag_nxt;
    end
end

// ============================================================
// Named views of the latched flags, in the order they sit in the word.
wire       rail_a_overvoltage  = rail_flag_r[`SQS_BIT_A_OV];
wire       rail_a_undervoltage = rail_flag_r[`SQS_BIT_A_UV];
wire       rail_b_overvoltage  = rail_flag_r[`SQS_BIT_B_OV];
wire       rail_b_undervoltage = rail_flag_r[`SQS_BIT_B_UV];
wire       rail_c_overvoltage  = rail_flag_r[`SQS_BIT_C_OV];
wire       rail_c_undervoltage = rail_flag_r[`SQS_BIT_C_UV];
wire       rail_d_overvoltage  = rail_flag_r[`SQS_BIT_D_OV];
wire       rail_d_undervoltage = rail_flag_r[`SQS_BIT_D_UV];

// ============================================================
// Output enable gating. Enables follow the request, but a set rail flag
// forces its channel pair off until software clears the flag. The next
// flag value is used so the pair drops on the same edge the flag latches.
wire       rail_a_bad = rail_flag_nxt[`SQS_BIT_A_OV] | rail_flag_nxt[`SQS_BIT_A_UV];
wire       rail_b_bad = rail_flag_nxt[`SQS_BIT_B_OV] | rail_flag_nxt[`SQS_BIT_B_UV];
wire       rail_c_bad = rail_flag_nxt[`SQS_BIT_C_OV] | rail_flag_nxt[`SQS_BIT_C_UV];
wire       rail_d_bad = rail_flag_nxt[`SQS_BIT_D_OV] | rail_flag_nxt[`SQS_BIT_D_UV];
wire [7:0] pair_kill;

assign pair_kill = {rail_d_bad, rail_d_bad, rail_c_bad, rail_c_bad,
                    rail_b_bad, rail_b_bad, rail_a_bad, rail_a_bad};

always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        channel_output_enable <= 8'h00;
    end else begin
        channel_output_enable <= channel_output_enable_req & ~pair_kill;
    end
end

// ============================================================
// Header and quick status terms.
wire       fail_mode_sync;
wire       supply_fault_summary;
wire       device_fault_summary;
wire [7:0] channel_fault_summary;

assign fail_mode_sync        = dev_s2_r[6];
assign supply_fault_summary  = |rail_flag_r;
assign device_fault_summary  = |dev_s2_r[5:0];
assign channel_fault_summary = chn_s2_r[39:32]
                             | chn_s2_r[31:24]
                             | chn_s2_r[23:16]
                             | chn_s2_r[15:8]
                             | chn_s2_r[7:0];

// ============================================================
// Word assembly. Bit 9 carries no meaning and is held at zero so a reader
// that forgets to mask it still sees a stable value.
reg  [15:0] supply_word;
reg  [15:0] quick_word;

always @* begin
    supply_word = `SQS_RST_WORD;
    supply_word[`SQS_ADDR_HI:`SQS_ADDR_LO] = `SQS_ADDR_SUPPLY;
    supply_word[`SQS_BIT_FAIL]             = fail_mode_sync;
    supply_word[`SQS_BIT_SUPPLY_SUM]       = supply_fault_summary;
    supply_word[`SQS_BIT_DC]               = 1'h0;
    supply_word[`SQS_BIT_DEVICE_SUM]       = device_fault_summary;
    supply_word[`SQS_BIT_A_OV]             = rail_a_overvoltage;
    supply_word[`SQS_BIT_A_UV]             = rail_a_undervoltage;
    supply_word[`SQS_BIT_B_OV]             = rail_b_overvoltage;
    supply_word[`SQS_BIT_B_UV]             = rail_b_undervoltage;
    supply_word[`SQS_BIT_C_OV]             = rail_c_overvoltage;
    supply_word[`SQS_BIT_C_UV]             = rail_c_undervoltage;
    supply_word[`SQS_BIT_D_OV]             = rail_d_overvoltage;
    supply_word[`SQS_BIT_D_UV]             = rail_d_undervoltage;
end

always @* begin
    quick_word = `SQS_RST_WORD;
    quick_word[`SQS_ADDR_HI:`SQS_ADDR_LO]   = `SQS_ADDR_QUICK;
    quick_word[`SQS_BIT_FAIL]               = fail_mode_sync;
    quick_word[`SQS_BIT_SUPPLY_SUM]         = supply_fault_summary;
    quick_word[`SQS_BIT_DC]                 = 1'h0;
    quick_word[`SQS_BIT_DEVICE_SUM]         = device_fault_summary;
    quick_word[`SQS_QUICK_HI:`SQS_QUICK_LO] = channel_fault_summary;
end

// ============================================================
// Read port. Data appears one cycle after the read strobe; unmapped
// addresses return zero so the host never sees stale data.
always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
        reg_rdata  <= `SQS_RST_WORD;
        reg_rvalid <= 1'h0;
    end else begin
        reg_rvalid <= reg_rd;
        if (reg_rd) begin
            case (reg_addr)
                `SQS_ADDR_SUPPLY: reg_rdata <= supply_word;
                `SQS_ADDR_QUICK:  reg_rdata <= quick_word;
                default:          reg_rdata <= `SQS_RST_WORD;
            endcase
        end
    end
end

endmodule

// [tb/sqs_host_model.sv]
`timescale 1ns/1ps
module sqs_host_model (
    input  wire logic   clk,
    output logic        reg_rd,
    output logic        reg_wr,
    output logic [3:0]  reg_addr,
    output logic [15:0] reg_wdata);
initial {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'h0, 4'hF, 16'h0000};
// Idle address and data lines carry the inverse of the last transfer so stale sampling shows; both strobes idle low.
task automatic xfer(input logic w, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    #1;
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {!w, w, a, d};
    @(posedge clk);
    #1;
    {reg_rd, reg_wr, reg_addr, reg_wdata} = {2'b00, ~a, ~d};
endtask
endmodule

// [tb/sqs_status_regs_asserts.sv]
`timescale 1ns/1ps
module sqs_status_regs_asserts (
    input wire logic        clk, reset_n, reg_rd, reg_rvalid,
    input wire logic [3:0]  reg_addr,
    input wire logic [15:0] reg_rdata,
    input wire logic        switch_supply_a_ov, switch_supply_a_uv, switch_supply_b_ov,
    input wire logic        switch_supply_b_uv, switch_supply_c_ov, switch_supply_c_uv,
    input wire logic        switch_supply_d_ov, switch_supply_d_uv,
    input wire logic [7:0]  channel_output_enable_req,
    input wire logic [7:0]  channel_output_enable);
default clocking @(posedge clk); endclocking
default disable iff (!reset_n);
property p_ans; reg_rd |=> reg_rvalid; endproperty
a_ans: assert property (p_ans) else $error("no read answer");
property p_adr; reg_rd && reg_addr == 4'h4 |=> reg_rdata[15:12] == 4'h4; endproperty
a_adr: assert property (p_adr) else $error("bad address field");
property p_dc; reg_rvalid |-> !reg_rdata[9]; endproperty
a_dc: assert property (p_dc) else $error("bit 9 set");
property p_svf; reg_rd && reg_addr == 4'h3 |=> reg_rdata[10] == |reg_rdata[7:0]; endproperty
a_svf: assert property (p_svf) else $error("bad supply summary");
property p_map; reg_rd && reg_addr > 4'h4 |=> reg_rdata == 16'h0000; endproperty
a_map: assert property (p_map) else $error("unmapped read not zero");
property p_ra; switch_supply_a_ov || switch_supply_a_uv
    |-> ##3 channel_output_enable[1:0] == 2'h0; endproperty
a_ra: assert property (p_ra) else $error("rail a enables on");
property p_rb; switch_supply_b_ov || switch_supply_b_uv
    |-> ##3 channel_output_enable[3:2] == 2'h0; endproperty
a_rb: assert property (p_rb) else $error("rail b enables on");
property p_rc; switch_supply_c_ov || switch_supply_c_uv
    |-> ##3 channel_output_enable[5:4] == 2'h0; endproperty
a_rc: assert property (p_rc) else $error("rail c enables on");
property p_rd; switch_supply_d_ov || switch_supply_d_uv
    |-> ##3 channel_output_enable[7:6] == 2'h0; endproperty
a_rd: assert property (p_rd) else $error("rail d enables on");
property p_req;
    (channel_output_enable & ~$past(channel_output_enable_req)) == 8'h00; endproperty
a_req: assert property (p_req) else $error("enable without request");
endmodule
bind sqs_status_regs sqs_status_regs_asserts chk (.clk, .reset_n, .reg_rd, .reg_rvalid,
    .reg_addr, .reg_rdata, .switch_supply_a_ov, .switch_supply_a_uv, .switch_supply_b_ov,
    .switch_supply_b_uv, .switch_supply_c_ov, .switch_supply_c_uv, .switch_supply_d_ov,
    .switch_supply_d_uv, .channel_output_enable_req, .channel_output_enable);

// [tb/sqs_status_regs_test.sv]
`timescale 1ns/1ps
module sqs_status_regs_test;
logic        clk = 1'b0, reset_n = 1'b0, fail_mode_flag = 1'b0, reg_rd, reg_wr, reg_rvalid;
logic [3:0]  reg_addr;
logic [15:0] reg_wdata, reg_rdata;
logic [7:0]  sv = 8'h00, channel_output_enable, channel_output_enable_req = 8'hFF;
logic [5:0]  df = 6'h00;
logic [39:0] ch = 40'h0;
int          err_total = 0, num_checks = 0;
always #2 clk = ~clk;
sqs_host_model host (.clk, .reg_rd, .reg_wr, .reg_addr, .reg_wdata);
sqs_status_regs uut (.clk(clk), .reset_n(reset_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .fail_mode_flag(fail_mode_flag),
    .channel_output_enable_req(channel_output_enable_req),
    .channel_output_enable(channel_output_enable),
    .switch_supply_a_ov(sv[7]), .switch_supply_a_uv(sv[6]),
    .switch_supply_b_ov(sv[5]), .switch_supply_b_uv(sv[4]), .switch_supply_c_ov(sv[3]),
    .switch_supply_c_uv(sv[2]), .switch_supply_d_ov(sv[1]), .switch_supply_d_uv(sv[0]),
    .logic_supply_fault(df[0]), .serial_frame_fault(df[1]), .fallback_input(df[2]),
    .pwm_clock_fault(df[3]), .ext_resistor_fault(df[4]), .watchdog_error(df[5]),
    .channel_thermal_shutdown(ch[7:0]), .channel_thermal_warn_high(ch[15:8]),
    .channel_thermal_warn_low(ch[23:16]), .channel_overcurrent(ch[31:24]),
    .channel_open_load(ch[39:32]));
task chk(input string n, input logic [15:0] e, g);
    num_checks++;
    if (g !== e) begin
        err_total++;
        $display("[ERR] %s expected %h seen %h", n, e, g);
    end
endtask
task rd(input logic [3:0] a, input logic [15:0] e);
    host.xfer(1'b0, a, 16'h0000);
    chk("rvalid", 16'h0001, {15'h0, reg_rvalid});
    chk("rdata", e, reg_rdata);
endtask
task drive(input logic f, input logic [5:0] d, input logic [39:0] c);
    @(posedge clk);
    #1 {fail_mode_flag, df, ch} = {f, d, c};
    repeat (4) @(posedge clk);
endtask
task t_rails;
    for (int b = 0; b < 8; b++) begin
        drive(1'b0, 6'h00, 40'h0);
        #1 sv = 8'h01 << b;
        drive(1'b0, 6'h00, 40'h0);
        #1 sv = 8'h00;
        repeat (4) @(posedge clk);
        #1 chk("enable", {8'h00, ~(8'h03 << (6 - b / 2 * 2))}, {8'h00, channel_output_enable});
        host.xfer(1'b1, 4'h4, 16'h00FF);
        rd(4'h3, 16'h3400 | (16'h0001 << b));
        rd(4'h4, 16'h4400);
        host.xfer(1'b1, 4'h3, 16'h0001 << b);
        rd(4'h3, 16'h3000);
        chk("enable", 16'h00FF, {8'h00, channel_output_enable});
    end
endtask
task t_setwins;
    drive(1'b0, 6'h00, 40'h0);
    #1 sv = 8'h80;
    drive(1'b0, 6'h00, 40'h0);
    host.xfer(1'b1, 4'h3, 16'h0080);
    sv = 8'h00;
    rd(4'h3, 16'h3480);
    host.xfer(1'b1, 4'h3, 16'h0080);
    rd(4'h3, 16'h3000);
    chk("enable", 16'h00FF, {8'h00, channel_output_enable});
endtask
task t_req;
    @(posedge clk);
    #1 {channel_output_enable_req, sv} = {8'hA5, 8'h20};
    @(posedge clk);
    #1 chk("enable", 16'h00A5, {8'h00, channel_output_enable});
    repeat (4) @(posedge clk);
    #1 chk("enable", 16'h00A1, {8'h00, channel_output_enable});
    sv = 8'h00;
    repeat (4) @(posedge clk);
    host.xfer(1'b1, 4'h3, 16'h0020);
    rd(4'h3, 16'h3000);
    chk("enable", 16'h00A5, {8'h00, channel_output_enable});
endtask
task t_hdr;
    drive(1'b1, 6'h00, 40'h0);
    rd(4'h4, 16'h4800);
    for (int k = 0; k < 6; k++) begin
        drive(1'b0, 6'h01 << k, 40'h0);
        rd(4'h3, 16'h3100);
    end
    for (int k = 0; k < 40; k++) begin
        drive(1'b0, 6'h00, 40'h1 << k);
        rd(4'h4, 16'h4000 | (16'h0001 << (k % 8)));
    end
endtask
task complete_run;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
initial begin
    repeat (5) @(posedge clk);
    #1 reset_n = 1'b1;
    rd(4'h3, 16'h3000);
    rd(4'h5, 16'h0000);
    t_rails;
    t_setwins;
    t_req;
    t_hdr;
    complete_run;
end
initial begin
    #40000;
    err_total++;
    complete_run;
end
endmodule
